// ### srs_pkg.sv
// constants, types and helpers for the two-wire register slave
// ---------------------------------------------------------------
// Function
// R01 - sensor is a bus slave only; it never starts a transfer
// R02 - serial clock is an input only; never pulled low, no stretching
// R03 - data line is only pulled low or released, phase decides who drives
// R04 - bus is idle while clock and data are both high
// R05 - only the master makes start and stop conditions
// R06 - transfers: start, address byte, ack or nack bits, bytes, stop
// R07 - master can read and write the internal register space
// R08 - read-only revision register gives silicon and memory revisions
// R09 - reset input restores every register to its default at once
// R10 - writing the reset control register also resets the registers
// R11 - address-select input chooses which slave address is answered
// R12 - start is data falling, stop is data rising, with clock high
// R13 - default address 0x20/0x21, alternate 0x30/0x31 when selected
// R14 - write: 16-bit register address high then low, each byte acked
// R15 - register pointer advances after each byte; nack ends a read
// R16 - clock and data inputs are synchronised and deglitched first
// R17 - on mismatch or stop the data line is released, wait for start
// ---------------------------------------------------------------
package srs_pkg;
    // ---------------------------------------------------------------
    // slave addresses and register map
    // ---------------------------------------------------------------
    localparam logic [6:0] ADDR_DEFAULT = 7'h10;
    localparam logic [6:0] ADDR_ALT = 7'h18;
    localparam logic [15:0] REV_HI_ADDR = 16'h0000;
    localparam logic [15:0] REV_LO_ADDR = 16'h0001;
    localparam logic [15:0] RST_CTRL_ADDR = 16'h0010;
    localparam int RST_CTRL_BIT = 0;
    localparam logic [15:0] REG_BASE = 16'h3000;
    localparam int REG_DEPTH = 64;
    localparam int REG_AW = 6;
    localparam logic [7:0] REG_RESET = 8'h00;
    // ---------------------------------------------------------------
    // input filter and byte framing
    // ---------------------------------------------------------------
    localparam logic [1:0] FILT_CNT = 2'h2;
    localparam logic [3:0] BYTE_BITS = 4'h8;

    typedef enum logic [2:0] {
        st_idle, st_rx, st_ack, st_tx, st_mack
    } srs_state_type;

    typedef enum logic [1:0] {
        ph_dev, ph_hi, ph_lo, ph_data
    } srs_phase_type;

    // pointer lands inside the writable register bank
    function automatic logic in_bank(input logic [15:0] ptr);
        in_bank = (ptr[15:REG_AW] == REG_BASE[15:REG_AW]);
    endfunction

    // glitch filter step: returns {filtered level, count}
    function automatic logic [2:0] filt_step(input logic raw,
                                             input logic lvl,
                                             input logic [1:0] cnt);
        if (raw == lvl) begin
            filt_step = {lvl, 2'h0};
        end else if (cnt == FILT_CNT) begin
            filt_step = {raw, 2'h0};
        end else begin
            filt_step = {lvl, cnt + 2'h1};
        end
    endfunction
endpackage

// ### srs_mem_if.sv
// write and read port between the slave and its register bank
interface srs_mem_if;
    logic we;
    logic clr;
    logic [5:0] waddr;
    logic [7:0] wdata;
    logic [5:0] raddr;
    logic [7:0] rdata;

    modport ctrl (output we, output clr, output waddr, output wdata,
                  output raddr, input rdata);
    modport mem (input we, input clr, input waddr, input wdata,
                 input raddr, output rdata);
endinterface

// ### srs_reg_mem.sv
// register bank of the serial slave, registered read data
module srs_reg_mem (
    input wire logic clk,
    input wire logic reset,
    srs_mem_if.mem port
);
    typedef struct packed {
        logic [srs_pkg::REG_DEPTH-1:0][7:0] regs;
        logic [7:0] rdata;
    } srs_mem_state_type;

    srs_mem_state_type r;
    srs_mem_state_type next_r;

    always_comb begin
        next_r = r;
        // ---------------------------------------------------------------
        // soft reset clears the bank, clear wins over a write
        // ---------------------------------------------------------------
        // R10 register reset
        if (port.clr) begin
            next_r.regs = {srs_pkg::REG_DEPTH{srs_pkg::REG_RESET}};
        end else if (port.we) begin
            next_r.regs[port.waddr] = port.wdata;
        end
        next_r.rdata = r.regs[port.raddr];
    end

    // R09 async defaults
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign port.rdata = r.rdata;

    // R07 write reaches bank
    write_lands_a: assert property (@(posedge clk) disable iff (reset) // R07
        port.we && !port.clr |=>
        r.regs[$past(port.waddr)] == $past(port.wdata))
        else $error("written byte missing from bank");
    // R10 clear empties bank
    clear_empties_a: assert property (@(posedge clk) disable iff (reset) // R10
        port.clr ##1 !port.we[*2] |-> port.rdata == srs_pkg::REG_RESET)
        else $error("register not cleared by soft reset");
endmodule

// ### srs_slave.sv
// two-wire register slave of the sensor, top level
module srs_slave #(
    // arbitrary neutral revision values
    parameter logic [7:0] SILICON_REV = 8'h01,
    parameter logic [7:0] ONE_TIME_PROGRAM_MEMORY_REV = 8'h01
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    input wire logic bus_address_select_in,
    input wire logic addr_select_enable,
    output logic bus_idle
);
    typedef struct packed {
        logic [1:0] scl_sync;
        logic [1:0] sda_sync;
        logic [1:0] sel_sync;
        logic [1:0] en_sync;
        logic scl_f;
        logic sda_f;
        logic [1:0] scl_cnt;
        logic [1:0] sda_cnt;
        srs_pkg::srs_state_type st;
        srs_pkg::srs_phase_type phase;
        logic [3:0] bitcnt;
        logic [7:0] shreg;
        logic rw;
        logic [15:0] ptr;
        logic sda_oe_n;
        logic sda_out;
        logic bus_idle;
        logic mem_we;
        logic mem_clr;
        logic [5:0] waddr;
        logic [7:0] wdata;
    } srs_top_state_type;

    srs_top_state_type r;
    srs_top_state_type next_r;
    srs_mem_if mif();

    logic rise;
    logic fall;
    logic start;
    logic stop;
    logic match;
    logic [6:0] own_addr;
    logic [7:0] rd_byte;

    srs_reg_mem u_mem (
        .clk(clk),
        .reset(reset),
        .port(mif.mem)
    );

    assign mif.we = r.mem_we;
    assign mif.clr = r.mem_clr;
    assign mif.waddr = r.waddr;
    assign mif.wdata = r.wdata;
    assign mif.raddr = r.ptr[5:0];

    always_comb begin
        next_r = r;
        // ---------------------------------------------------------------
        // input synchronisers and glitch filters
        // ---------------------------------------------------------------
        next_r.scl_sync = {r.scl_sync[0], scl_in};
        next_r.sda_sync = {r.sda_sync[0], sda_in};
        next_r.sel_sync = {r.sel_sync[0], bus_address_select_in};
        next_r.en_sync = {r.en_sync[0], addr_select_enable};
        // R16 filter before edges
        {next_r.scl_f, next_r.scl_cnt} =
            srs_pkg::filt_step(r.scl_sync[1], r.scl_f, r.scl_cnt);
        {next_r.sda_f, next_r.sda_cnt} =
            srs_pkg::filt_step(r.sda_sync[1], r.sda_f, r.sda_cnt);
        rise = !r.scl_f && next_r.scl_f;
        fall = r.scl_f && !next_r.scl_f;
        // R12 start and stop
        start = r.scl_f && next_r.scl_f && r.sda_f && !next_r.sda_f;
        stop = r.scl_f && next_r.scl_f && !r.sda_f && next_r.sda_f;
        // R04 idle flag
        next_r.bus_idle = next_r.scl_f && next_r.sda_f;
        // R11 address select
        own_addr = (r.en_sync[1] && r.sel_sync[1]) ?
            srs_pkg::ADDR_ALT : srs_pkg::ADDR_DEFAULT;
        // R13 address compare
        match = (r.shreg[7:1] == own_addr);
        // R08 revision register
        if (r.ptr == srs_pkg::REV_HI_ADDR) begin
            rd_byte = SILICON_REV;
        end else if (r.ptr == srs_pkg::REV_LO_ADDR) begin
            rd_byte = ONE_TIME_PROGRAM_MEMORY_REV;
        end else if (srs_pkg::in_bank(r.ptr)) begin
            rd_byte = mif.rdata;
        end else begin
            rd_byte = 8'h00;
        end
        // R03 only ever pull low
        next_r.sda_out = 1'b0;
        next_r.mem_we = 1'b0;
        next_r.mem_clr = 1'b0;
        // ---------------------------------------------------------------
        // protocol engine; acts on master clock edges and on start and stop conditions
        // ---------------------------------------------------------------
        // R06 start, bytes, acks, stop
        // R01 slave only
        if (start) begin
            next_r.st = srs_pkg::st_rx;
            next_r.phase = srs_pkg::ph_dev;
            next_r.bitcnt = 4'h0;
            next_r.sda_oe_n = 1'b1;
        end else if (stop) begin
            // R17 release on stop
            next_r.st = srs_pkg::st_idle;
            next_r.sda_oe_n = 1'b1;
        end else begin
            unique case (r.st)
                srs_pkg::st_idle: begin
                    next_r.sda_oe_n = 1'b1;
                end
                srs_pkg::st_rx: begin
                    if (rise) begin
                        next_r.shreg = {r.shreg[6:0], next_r.sda_f};
                        next_r.bitcnt = r.bitcnt + 4'h1;
                    end else if (fall && r.bitcnt == srs_pkg::BYTE_BITS) begin
                        // R14 ack each byte
                        next_r.sda_oe_n = 1'b0;
                        next_r.st = srs_pkg::st_ack;
                        unique case (r.phase)
                            srs_pkg::ph_dev: begin
                                next_r.rw = r.shreg[0];
                                next_r.phase = srs_pkg::ph_hi;
                                // R17 mismatch releases
                                if (!match) begin
                                    next_r.sda_oe_n = 1'b1;
                                    next_r.st = srs_pkg::st_idle;
                                end
                            end
                            srs_pkg::ph_hi: begin
                                next_r.ptr[15:8] = r.shreg;
                                next_r.phase = srs_pkg::ph_lo;
                            end
                            srs_pkg::ph_lo: begin
                                next_r.ptr[7:0] = r.shreg;
                                next_r.phase = srs_pkg::ph_data;
                            end
                            srs_pkg::ph_data: begin
                                // R07 register write
                                next_r.mem_we = srs_pkg::in_bank(r.ptr);
                                next_r.waddr = r.ptr[5:0];
                                next_r.wdata = r.shreg;
                                // R10 soft reset
                                next_r.mem_clr =
                                    r.ptr == srs_pkg::RST_CTRL_ADDR &&
                                    r.shreg[srs_pkg::RST_CTRL_BIT];
                                // R15 advance pointer
                                next_r.ptr = r.ptr + 16'h0001;
                            end
                        endcase
                    end
                end
                srs_pkg::st_ack: begin
                    if (fall) begin
                        next_r.bitcnt = 4'h0;
                        next_r.sda_oe_n = 1'b1;
                        next_r.st = srs_pkg::st_rx;
                        if (r.rw) begin
                            next_r.st = srs_pkg::st_tx;
                            next_r.sda_oe_n = rd_byte[7];
                            next_r.shreg = {rd_byte[6:0], 1'b0};
                            next_r.bitcnt = 4'h1;
                        end
                    end
                end
                srs_pkg::st_tx: begin
                    if (fall && r.bitcnt == srs_pkg::BYTE_BITS) begin
                        next_r.sda_oe_n = 1'b1;
                        next_r.st = srs_pkg::st_mack;
                        // R15 advance after read byte
                        next_r.ptr = r.ptr + 16'h0001;
                    end else if (fall) begin
                        next_r.sda_oe_n = r.shreg[7];
                        next_r.shreg = {r.shreg[6:0], 1'b0};
                        next_r.bitcnt = r.bitcnt + 4'h1;
                    end
                end
                srs_pkg::st_mack: begin
                    // R15 nack ends read
                    if (rise && next_r.sda_f) begin
                        next_r.st = srs_pkg::st_idle;
                    end else if (fall) begin
                        next_r.st = srs_pkg::st_tx;
                        next_r.sda_oe_n = rd_byte[7];
                        next_r.shreg = {rd_byte[6:0], 1'b0};
                        next_r.bitcnt = 4'h1;
                    end
                end
                default: begin
                    next_r.st = srs_pkg::st_idle;
                    next_r.sda_oe_n = 1'b1;
                end
            endcase
        end
    end

    // R09 async reset to defaults
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            r <= '0;
            // idle level in the syncs, no false edge after reset
            r.scl_sync <= 2'h3;
            r.sda_sync <= 2'h3;
            r.scl_f <= 1'b1;
            r.sda_f <= 1'b1;
            r.sda_oe_n <= 1'b1;
            r.bus_idle <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    // R02 clock never driven, no output exists for it
    assign sda_out = r.sda_out;
    assign sda_oe_n = r.sda_oe_n;
    assign bus_idle = r.bus_idle;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence addr_byte_done;
        r.st == srs_pkg::st_rx && fall && r.phase == srs_pkg::ph_dev &&
        r.bitcnt == srs_pkg::BYTE_BITS;
    endsequence
    sequence data_byte_done;
        r.st == srs_pkg::st_rx && fall && r.phase == srs_pkg::ph_data &&
        r.bitcnt == srs_pkg::BYTE_BITS && !start && !stop;
    endsequence

    drive_low_only_a: assert property (!sda_oe_n |-> sda_out == 1'b0 && // R03
        (r.st == srs_pkg::st_ack || r.st == srs_pkg::st_tx))
        else $error("data line driven outside ack or read phase");
    idle_flag_a: assert property ( // R04
        next_r.scl_f && next_r.sda_f |=> bus_idle)
        else $error("idle bus not flagged");
    start_frames_a: assert property (start |=> r.st == srs_pkg::st_rx && // R12
        r.phase == srs_pkg::ph_dev && r.bitcnt == 4'h0 && sda_oe_n)
        else $error("start did not open address byte");
    stop_release_a: assert property (stop |=> r.st == srs_pkg::st_idle // R17
        && sda_oe_n)
        else $error("stop did not release the bus");
    mismatch_idle_a: assert property (addr_byte_done and !start && !stop // R11
        && !match |=> r.st == srs_pkg::st_idle && sda_oe_n[*2])
        else $error("mismatched address was answered");
    match_ack_a: assert property (addr_byte_done and !start && !stop // R13
        && match |=> !sda_oe_n && r.st == srs_pkg::st_ack)
        else $error("matching address not acknowledged");
    write_advance_a: assert property (data_byte_done |=> // R15
        r.ptr == $past(r.ptr) + 16'h0001 ##1 mif.wdata == $past(r.shreg, 2))
        else $error("pointer or write data wrong after byte");
    soft_reset_a: assert property (data_byte_done and // R10
        r.ptr == srs_pkg::RST_CTRL_ADDR && r.shreg[0] |=> mif.clr)
        else $error("reset control write did not clear");
    filter_hold_a: assert property ($changed(r.sda_f) |-> // R16
        $past(r.sda_sync[1], 1) == r.sda_f &&
        $past(r.sda_sync[1], 3) == r.sda_f)
        else $error("data filter passed a glitch");
endmodule

// ### srs_master_model.sv
// two-wire bus master model driving the slave's serial pins
module srs_master_model (
    input wire logic clk,
    input wire logic sda_wire,
    output logic scl,
    output logic sda_low,
    output logic res_valid,
    output logic [7:0] res_data
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
        res_valid = 1'b0;
        res_data = 8'h00;
    end

    // random span so the link drifts against clk
    task automatic hold();
        repeat (8 + $urandom_range(0, 3)) @(posedge clk);
    endtask

    task automatic clock_bit(input logic b, output logic got);
        repeat (4) @(posedge clk);
        sda_low <= ~b;
        hold();
        @(negedge clk) got = sda_wire;
        @(posedge clk) scl <= 1'b1;
        hold();
        scl <= 1'b0;
    endtask

    task automatic post(input logic [7:0] v);
        res_data <= v;
        res_valid <= 1'b1;
        @(posedge clk);
        res_valid <= 1'b0;
    endtask

    task automatic start_cond();
        repeat (4) @(posedge clk);
        sda_low <= 1'b0;
        hold();
        scl <= 1'b1;
        hold();
        sda_low <= 1'b1;
        hold();
        scl <= 1'b0;
    endtask

    task automatic stop_cond();
        repeat (4) @(posedge clk);
        sda_low <= 1'b1;
        hold();
        scl <= 1'b1;
        hold();
        sda_low <= 1'b0;
        hold();
    endtask

    task automatic send_byte(input logic [7:0] b);
        logic got;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(b[i], got);
        end
        clock_bit(1'b1, got);
        post({7'h00, got});
    endtask

    // master acks or nacks each byte read
    task automatic recv_byte(input logic nack);
        logic [7:0] d;
        logic got;
        d = 8'h00;
        for (int i = 0; i < 8; i++) begin
            clock_bit(1'b1, got);
            d = {d[6:0], got};
        end
        clock_bit(nack, got);
        post(d);
    endtask
endmodule

// ### tb_sensor_two_wire_register_slave.sv
// self-checking bench for the two-wire register slave
module tb_sensor_two_wire_register_slave;
    timeunit 1ns;
    timeprecision 1ps;
    // revision values are arbitrary
    localparam logic [7:0] SIL_REV = 8'h5a;
    localparam logic [7:0] MEM_REV = 8'hc3;
    typedef struct packed {
        logic kind;
        logic [7:0] val;
    } srs_note_type;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic sel_en = 1'b0;
    logic sel_in = 1'b0;
    logic scl, sda_low, sda_wire, sda_out, sda_oe_n, bus_idle, res_valid;
    logic [7:0] res_data;
    logic [6:0] dev = srs_pkg::ADDR_DEFAULT;
    logic [15:0] cur_ptr = 16'h0000;
    logic [15:0] base;
    logic [7:0] mem [64];
    srs_note_type notes [$];
    srs_note_type note;
    int failures = 0;
    int checks = 0;

    initial begin
        forever #12.5 clk = ~clk;
    end

    // wire is low if either side pulls it
    assign sda_wire = !(sda_low || (sda_oe_n == 1'b0 && sda_out == 1'b0));

    srs_slave #(
        .SILICON_REV(SIL_REV),
        .ONE_TIME_PROGRAM_MEMORY_REV(MEM_REV)
    ) i_srs_slave (
        .clk(clk), .reset(reset), .scl_in(scl), .sda_in(sda_wire),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .bus_address_select_in(sel_in), .addr_select_enable(sel_en),
        .bus_idle(bus_idle));
    srs_master_model i_model (
        .clk(clk), .sda_wire(sda_wire), .scl(scl), .sda_low(sda_low),
        .res_valid(res_valid), .res_data(res_data));

    task automatic tally_and_finish();
        if (failures == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_bit(input logic got, input logic exp);
        cmp_byte({7'h00, got}, {7'h00, exp});
    endtask

    function automatic logic [7:0] exp_rd(input logic [15:0] p);
        if (p == srs_pkg::REV_HI_ADDR) return SIL_REV;
        if (p == srs_pkg::REV_LO_ADDR) return MEM_REV;
        if (p[15:6] == srs_pkg::REG_BASE[15:6]) return mem[p[5:0]];
        return 8'h00;
    endfunction

    task automatic wr_byte(input logic [7:0] b, input logic exp_ack);
        notes.push_back('{1'b0, {7'h00, exp_ack}});
        i_model.send_byte(b);
    endtask

    task automatic addr_phase(input logic [15:0] p);
        i_model.start_cond();
        wr_byte({dev, 1'b0}, 1'b0);
        wr_byte(p[15:8], 1'b0);
        wr_byte(p[7:0], 1'b0);
        cur_ptr = p;
    endtask

    task automatic write_regs(input logic [15:0] p, input int n,
                              input logic [7:0] first);
        logic [7:0] d;
        addr_phase(p);
        for (int i = 0; i < n; i++) begin
            d = (i == 0) ? first : 8'($urandom_range(0, 255));
            wr_byte(d, 1'b0);
            if (cur_ptr[15:6] == srs_pkg::REG_BASE[15:6]) begin
                mem[cur_ptr[5:0]] = d;
            end
            if (cur_ptr == srs_pkg::RST_CTRL_ADDR && d[0]) mem = '{default: 0};
            cur_ptr++;
        end
        i_model.stop_cond();
    endtask

    task automatic read_regs(input logic [15:0] p, input int n,
                             input logic cur);
        if (!cur) addr_phase(p);
        i_model.start_cond();
        wr_byte({dev, 1'b1}, 1'b0);
        for (int i = 0; i < n; i++) begin
            notes.push_back('{1'b1, exp_rd(cur_ptr)});
            i_model.recv_byte(i == n - 1);
            cur_ptr++;
        end
        i_model.stop_cond();
    endtask

    always @(posedge clk) begin
        if (res_valid === 1'b1) begin
            if (notes.size() == 0) cmp_byte(8'(notes.size()), 8'h01);
            else begin
                note = notes.pop_front();
                if (note.kind) cmp_byte(res_data, note.val);
                else cmp_bit(res_data[0], note.val[0]);
            end
        end
        if (sda_oe_n === 1'b0) cmp_bit(sda_out, 1'b0);
    end

    initial begin
        repeat (60000) @(posedge clk);
        failures++;
        tally_and_finish();
    end

    initial begin
        void'($urandom(32'heb54));
        mem = '{default: 0};
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        repeat (6) @(posedge clk);
        cmp_bit(bus_idle, 1'b1);
        cmp_bit(sda_oe_n, 1'b1);
        // every enable and select combination, both addresses
        for (int m = 0; m < 4; m++) begin
            sel_en <= m[1];
            sel_in <= m[0];
            repeat (8) @(posedge clk);
            dev = (m == 3) ? srs_pkg::ADDR_ALT : srs_pkg::ADDR_DEFAULT;
            for (int k = 0; k < 2; k++) begin
                base[6:0] = k ? srs_pkg::ADDR_ALT : srs_pkg::ADDR_DEFAULT;
                i_model.start_cond();
                wr_byte({base[6:0], 1'b0}, base[6:0] != dev);
                wr_byte(8'h00, base[6:0] != dev);
                i_model.stop_cond();
            end
        end
        // two-cycle dip on the idle clock must not pass the filter
        i_model.scl <= 1'b0;
        repeat (2) @(posedge clk);
        i_model.scl <= 1'b1;
        repeat (8) begin
            @(posedge clk);
            cmp_bit(bus_idle, 1'b1);
        end
        repeat (8) @(posedge clk);
        cmp_bit(bus_idle, 1'b1);
        base = srs_pkg::REG_BASE + 16'($urandom_range(0, 59));
        write_regs(base, 4, 8'($urandom_range(0, 255)));
        read_regs(base, 4, 1'b0);
        read_regs(16'h0000, 1, 1'b1);
        write_regs(srs_pkg::REV_HI_ADDR, 1, 8'h3c);
        read_regs(srs_pkg::REV_HI_ADDR, 2, 1'b0);
        write_regs(16'h2ffe, 2, 8'h77);
        read_regs(16'h2ffe, 3, 1'b0);
        write_regs(srs_pkg::RST_CTRL_ADDR, 1, 8'h01);
        read_regs(base, 4, 1'b0);
        write_regs(base, 2, 8'ha5);
        // pin reset mid-run clears bank and pointer
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        cmp_bit(sda_oe_n, 1'b1);
        reset <= 1'b0;
        mem = '{default: 0};
        cur_ptr = 16'h0000;
        repeat (6) @(posedge clk);
        read_regs(16'h0000, 1, 1'b1);
        read_regs(base, 2, 1'b0);
        repeat (4) @(posedge clk);
        cmp_byte(8'(notes.size()), 8'h00);
        tally_and_finish();
    end
endmodule
